// >>> shared/amp_diag_pkg.sv
// Constants for the four-channel amplifier load diagnostics block
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`default_nettype none
package amp_diag_pkg;
    localparam int unsigned CLK_MHZ = 125;
    localparam int unsigned OFFSET_STEP_MS = 15;
    localparam int unsigned OFFSET_STEP_CYCLES = CLK_MHZ * 1000 * OFFSET_STEP_MS;
    localparam int unsigned MEAS_MS = 10;
    localparam int unsigned MEAS_CYCLES = CLK_MHZ * 1000 * MEAS_MS;
    localparam int unsigned TMR_W = 22;
    localparam int unsigned NUM_CH = 4;
    // Register map, byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_CH0 = 8'h08;
    localparam logic [7:0] ADDR_CH3 = 8'h14;
    // Control register fields
    localparam int unsigned B_START = 0;
    localparam int unsigned B_DIAG = 1;
    localparam int unsigned B_AC = 2;
    localparam int unsigned B_CURSEL = 3;
    localparam int unsigned B_RDSEL = 4;
    localparam int unsigned B_BESTEFF = 5;
    localparam int unsigned CTRL_W = 6;
    localparam logic [5:0] CTRL_RST = 6'h00;
    // Status register fields
    localparam int unsigned B_BUSY = 0;
    localparam int unsigned B_RUN = 1;
    localparam int unsigned B_POR = 2;
    localparam int unsigned B_STARTED = 3;
    // Load codes
    localparam logic [1:0] CODE_NORMAL = 2'h0;
    localparam logic [1:0] CODE_LINE = 2'h1;
    localparam logic [1:0] CODE_OPEN = 2'h2;
    localparam logic [1:0] CODE_INVALID = 2'h3;
    localparam logic [2:0] AC_CROSS_COUNT = 3'h4;
    localparam logic [2:0] RD_SEQ_FULL = 3'h4;
    typedef enum logic [2:0] {ST_IDLE, ST_RAMP, ST_MEAS, ST_FALL, ST_START, ST_RUN} seq_state_t;
endpackage : amp_diag_pkg
`default_nettype wire

// >>> logic/seq_timer.sv
// Down-counting interval timer with a one-cycle expiry pulse
`timescale 1ns/1ps
`default_nettype none
module seq_timer
    import amp_diag_pkg::*;
(
    // Clock and control
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Load
    input wire logic load_i,
    input wire logic [TMR_W-1:0] count_i,
    // Expiry
    output logic done_o
);
    logic [TMR_W-1:0] cnt_ff;
    logic run_ff;
    logic done_ff;
    wire last = run_ff && (cnt_ff == TMR_W'(1));

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_ff <= '0;
            run_ff <= 1'b0;
            done_ff <= 1'b0;
        end else if (ce_i) begin
            done_ff <= last && !load_i;
            if (load_i) begin
                cnt_ff <= count_i;
                run_ff <= 1'b1;
            end else if (run_ff) begin
                cnt_ff <= cnt_ff - TMR_W'(1);
                run_ff <= !last;
            end
        end
    end

    assign done_o = done_ff;
endmodule : seq_timer
`default_nettype wire

// >>> logic/chan_diag.sv
// Per-channel result latches: load code, short flags, offset latch, AC counter
`timescale 1ns/1ps
`default_nettype none
module chan_diag
    import amp_diag_pkg::*;
(
    // Clock and control
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Start-up diagnostic
    input wire logic diag_start_i,
    input wire logic diag_done_i,
    input wire logic invalid_i,
    input wire logic [1:0] dc_code_i,
    input wire logic short_load_i,
    input wire logic short_supply_i,
    input wire logic short_ground_i,
    input wire logic read_clear_i,
    input wire logic in_window_i,
    // AC detection
    input wire logic ac_reset_i,
    input wire logic ac_active_i,
    input wire logic peak_cross_i,
    // Results
    output logic [1:0] code_o,
    output logic [2:0] shorts_o,
    output logic offset_o,
    output logic ac_flag_o
);
    logic [1:0] code_ff;
    logic [2:0] shorts_ff;
    logic offset_ff;
    logic ac_ff;
    logic [2:0] cross_ff;
    wire [2:0] short_evt = {short_load_i, short_supply_i, short_ground_i};
    wire cross_ok = ac_active_i && peak_cross_i && !ac_ff;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            code_ff <= CODE_INVALID;
            shorts_ff <= 3'h0;
            offset_ff <= 1'b0;
        end else if (ce_i) begin
            if (diag_start_i) begin
                code_ff <= CODE_INVALID;
            end else if (diag_done_i) begin
                code_ff <= invalid_i ? CODE_INVALID : dc_code_i;
            end
            // Event wins over the read clear
            shorts_ff <= short_evt | (shorts_ff & {3{!read_clear_i}});
            if (read_clear_i) begin
                offset_ff <= 1'b1;
            end else if (in_window_i) begin
                offset_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cross_ff <= 3'h0;
            ac_ff <= 1'b0;
        end else if (ce_i) begin
            if (ac_reset_i) begin
                cross_ff <= 3'h0;
                ac_ff <= 1'b0;
            end else if (cross_ok) begin
                cross_ff <= cross_ff + 3'h1;
                ac_ff <= (cross_ff == AC_CROSS_COUNT - 3'h1);
            end
        end
    end

    assign code_o = code_ff;
    assign shorts_o = shorts_ff;
    assign offset_o = offset_ff;
    assign ac_flag_o = ac_ff;
endmodule : chan_diag
`default_nettype wire

// >>> logic/amp_load_diagnostics.sv
// Load diagnostics sequencer and Wishbone register file for four channels
//
// The address map and register access over Wishbone were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module amp_load_diagnostics
    import amp_diag_pkg::*;
#(
    parameter int unsigned OFFSET_STEP_CYC = OFFSET_STEP_CYCLES,
    parameter int unsigned MEAS_CYC = MEAS_CYCLES
) (
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Analog measurement results
    input wire logic [7:0] dc_code_i,
    input wire logic [3:0] over_3v5_i,
    input wire logic supply_dip_i,
    input wire logic supply_fault_i,
    input wire logic [3:0] short_load_i,
    input wire logic [3:0] short_supply_i,
    input wire logic [3:0] short_ground_i,
    input wire logic [3:0] in_window_i,
    input wire logic [3:0] peak_cross_i,
    // Amplifier status
    input wire logic midtap_reached_i,
    input wire logic shutdown_done_i,
    // Analog and amplifier control
    output logic offset_gen_o,
    output logic offset_raise_o,
    output logic amp_start_o,
    output logic ac_detect_o,
    output logic ac_high_current_o,
    output logic diag_release_o
);
    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic ack_ff;
    logic [31:0] dat_ff;
    logic [CTRL_W-1:0] ctrl_ff;
    logic [2:0] rd_seq_ff;
    logic read_clear_ff;
    wire take = wb_cyc_i && wb_stb_i && !ack_ff;
    wire rd = take && !wb_we_i;
    wire adr_ctrl = (wb_adr_i == ADDR_CTRL);
    wire adr_stat = (wb_adr_i == ADDR_STATUS);
    wire [7:0] ch_off = wb_adr_i - ADDR_CH0;
    wire [1:0] ch_idx = ch_off[3:2];
    wire ch_hit = (wb_adr_i >= ADDR_CH0) && (wb_adr_i <= ADDR_CH3) && (wb_adr_i[1:0] == 2'h0);
    wire wr_ctrl = take && wb_we_i && wb_sel_i[0] && adr_ctrl;
    wire [CTRL_W-1:0] ctrl_new = wb_dat_i[CTRL_W-1:0];
    wire start_rise = wr_ctrl && ctrl_new[B_START] && !ctrl_ff[B_START];
    wire diag_rise = wr_ctrl && ctrl_new[B_DIAG] && !ctrl_ff[B_DIAG];
    wire ac_rise = wr_ctrl && ctrl_new[B_AC] && !ctrl_ff[B_AC];
    // Five words in order: channels 0..3, then status
    wire seq_step = rd && ch_hit && (ch_idx == rd_seq_ff[1:0]) && (rd_seq_ff < RD_SEQ_FULL);
    wire seq_first = rd && ch_hit && (ch_idx == 2'h0);
    wire full_read = rd && adr_stat && (rd_seq_ff == RD_SEQ_FULL);
    wire [2:0] nxt_rd_seq = seq_step ? rd_seq_ff + 3'h1 : (seq_first ? 3'h1 : 3'h0);

    // ------------------------------------------------------------
    // Sequencer state
    // ------------------------------------------------------------
    seq_state_t state_ff;
    seq_state_t nxt_state;
    logic busy_ff;
    logic raise_ff;
    logic gen_ff;
    logic amp_ff;
    logic run_ff;
    logic started_ff;
    logic por_ff;
    logic abort_ff;
    logic fault_ff;
    logic ac_act_ff;
    logic nxt_raise;
    logic nxt_amp;
    logic ld_ramp;
    logic ld_meas;
    logic done_pulse;
    logic busy_clr;
    logic tmr_done;
    wire in_diag = (state_ff == ST_RAMP) || (state_ff == ST_MEAS) || (state_ff == ST_FALL);
    wire first_stage = (state_ff == ST_RAMP) || (state_ff == ST_MEAS);
    wire can_diag = ((state_ff == ST_IDLE) && !run_ff) || in_diag;
    wire diag_go = can_diag && wr_ctrl && ctrl_new[B_DIAG] && (diag_rise || start_rise);
    wire plain_start = (state_ff == ST_IDLE) && !run_ff && start_rise && !ctrl_new[B_DIAG];
    wire over_any = |over_3v5_i;
    wire ac_active = ctrl_ff[B_AC] && started_ff && !ctrl_ff[B_BESTEFF];
    wire [TMR_W-1:0] tmr_count = ld_meas ? TMR_W'(MEAS_CYC) : TMR_W'(OFFSET_STEP_CYC);

    seq_timer u_timer (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .load_i(ld_ramp || ld_meas),
        .count_i(tmr_count),
        .done_o(tmr_done)
    );

    always_comb begin
        nxt_state = state_ff;
        nxt_raise = raise_ff;
        nxt_amp = amp_ff;
        ld_ramp = 1'b0;
        ld_meas = 1'b0;
        done_pulse = 1'b0;
        busy_clr = 1'b0;
        case (state_ff)
            ST_IDLE: begin
                if (plain_start) begin
                    nxt_amp = 1'b1;
                    nxt_state = ST_START;
                end
            end
            ST_RAMP: begin
                if (over_any) begin
                    ld_ramp = 1'b1;
                    nxt_state = ST_FALL;
                end else if (tmr_done) begin
                    nxt_raise = 1'b1;
                    ld_meas = 1'b1;
                    nxt_state = ST_MEAS;
                end
            end
            ST_MEAS: begin
                if (over_any || tmr_done) begin
                    ld_ramp = 1'b1;
                    nxt_state = ST_FALL;
                end
            end
            ST_FALL: begin
                if (tmr_done) begin
                    nxt_raise = 1'b0;
                    done_pulse = 1'b1;
                    if (ctrl_ff[B_START]) begin
                        nxt_amp = 1'b1;
                        nxt_state = ST_START;
                    end else begin
                        busy_clr = 1'b1;
                        nxt_state = ST_IDLE;
                    end
                end
            end
            ST_START: begin
                if (!ctrl_ff[B_START]) begin
                    nxt_amp = 1'b0;
                    busy_clr = 1'b1;
                    nxt_state = ST_IDLE;
                end else if (midtap_reached_i) begin
                    busy_clr = 1'b1;
                    nxt_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (!ctrl_ff[B_START]) begin
                    nxt_amp = 1'b0;
                    nxt_state = ST_IDLE;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
        if (diag_go) begin
            nxt_state = ST_RAMP;
            nxt_raise = 1'b0;
            ld_ramp = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_ff <= ST_IDLE;
            raise_ff <= 1'b0;
            gen_ff <= 1'b0;
            amp_ff <= 1'b0;
        end else if (ce_i) begin
            state_ff <= nxt_state;
            raise_ff <= nxt_raise;
            gen_ff <= (nxt_state == ST_RAMP) || (nxt_state == ST_MEAS) || (nxt_state == ST_FALL);
            amp_ff <= nxt_amp;
        end
    end

    // ------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------
    // Reset acts as power-on reset: busy drops, reset flag rises
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            busy_ff <= 1'b0;
            por_ff <= 1'b1;
            run_ff <= 1'b0;
            started_ff <= 1'b0;
        end else if (ce_i) begin
            busy_ff <= diag_go || (busy_ff && !busy_clr);
            if (start_rise) begin
                por_ff <= 1'b0;
            end
            if (nxt_amp) begin
                run_ff <= 1'b1;
            end else if (shutdown_done_i) begin
                run_ff <= 1'b0;
            end
            started_ff <= amp_ff && (started_ff || midtap_reached_i);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            abort_ff <= 1'b0;
            fault_ff <= 1'b0;
            ac_act_ff <= 1'b0;
        end else if (ce_i) begin
            if (diag_go) begin
                abort_ff <= 1'b0;
                fault_ff <= 1'b0;
            end else begin
                abort_ff <= abort_ff || (first_stage && over_any);
                fault_ff <= fault_ff || (in_diag && (supply_dip_i || supply_fault_i));
            end
            ac_act_ff <= ac_active;
        end
    end

    // ------------------------------------------------------------
    // Channels
    // ------------------------------------------------------------
    logic [1:0] code_w [NUM_CH];
    logic [2:0] shorts_w [NUM_CH];
    logic [NUM_CH-1:0] offset_w;
    logic [NUM_CH-1:0] ac_w;
    logic [31:0] ch_word [NUM_CH];
    wire ch_invalid = abort_ff || fault_ff;

    for (genvar k = 0; k < NUM_CH; k++) begin : g_ch
        chan_diag u_ch (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .ce_i(ce_i),
            .diag_start_i(diag_go),
            .diag_done_i(done_pulse),
            .invalid_i(ch_invalid),
            .dc_code_i(dc_code_i[2*k +: 2]),
            .short_load_i(short_load_i[k]),
            .short_supply_i(short_supply_i[k]),
            .short_ground_i(short_ground_i[k]),
            .read_clear_i(read_clear_ff),
            .in_window_i(in_window_i[k]),
            .ac_reset_i(ac_rise),
            .ac_active_i(ac_active),
            .peak_cross_i(peak_cross_i[k]),
            .code_o(code_w[k]),
            .shorts_o(shorts_w[k]),
            .offset_o(offset_w[k]),
            .ac_flag_o(ac_w[k])
        );
        // Hidden results stay stored; only the view changes
        assign ch_word[k] = {26'h000_0000,
                             ctrl_ff[B_RDSEL] ? {1'b0, ac_w[k]} : code_w[k],
                             shorts_w[k][2], offset_w[k], shorts_w[k][1:0]};
    end

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    wire [31:0] stat_word = {28'h000_0000, started_ff, por_ff, run_ff, busy_ff};
    wire [31:0] ctrl_word = {26'h000_0000, ctrl_ff};
    wire [31:0] rd_word = adr_ctrl ? ctrl_word :
                          adr_stat ? stat_word :
                          ch_hit ? ch_word[ch_idx] : 32'h0000_0000;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_ff <= 1'b0;
            dat_ff <= 32'h0000_0000;
            ctrl_ff <= CTRL_RST;
            rd_seq_ff <= 3'h0;
            read_clear_ff <= 1'b0;
        end else if (ce_i) begin
            ack_ff <= take;
            read_clear_ff <= full_read;
            if (take) begin
                rd_seq_ff <= nxt_rd_seq;
            end
            if (rd) begin
                dat_ff <= rd_word;
            end
            if (wr_ctrl) begin
                ctrl_ff <= ctrl_new;
            end
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = dat_ff;
    assign offset_gen_o = gen_ff;
    assign offset_raise_o = raise_ff;
    assign amp_start_o = amp_ff;
    assign ac_detect_o = ac_act_ff;
    assign ac_high_current_o = ctrl_ff[B_CURSEL];
    assign diag_release_o = ctrl_ff[B_START];

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_ramp_end;
        ce_i && (state_ff == ST_RAMP) && tmr_done && !over_any && !diag_go;
    endsequence
    sequence s_meas_end;
        ce_i && (state_ff == ST_MEAS) && tmr_done && !over_any && !diag_go;
    endsequence

    a_raise_after_ramp: assert property (
        s_ramp_end |=> raise_ff && (state_ff == ST_MEAS))
        else $error("offset not raised at end of ramp");
    a_raise_held_fall: assert property (
        s_meas_end |=> raise_ff && (state_ff == ST_FALL))
        else $error("offset dropped before fall interval");
    a_abort_first_stage: assert property (
        (ce_i && first_stage && over_any && !diag_go) |=> abort_ff && (state_ff == ST_FALL))
        else $error("overvoltage did not abort diagnostic");
    a_busy_on_start: assert property (
        (ce_i && diag_go) |=> busy_ff && (code_w[0] == CODE_INVALID) && (code_w[3] == CODE_INVALID))
        else $error("diagnostic start did not set busy and invalid");
    a_busy_clear_done: assert property (
        (ce_i && (state_ff == ST_FALL) && tmr_done && !ctrl_ff[B_START] && !diag_go)
        |=> !busy_ff && (state_ff == ST_IDLE))
        else $error("busy not cleared at completion");
    a_busy_midtap: assert property (
        (ce_i && (state_ff == ST_START) && ctrl_ff[B_START] && midtap_reached_i)
        |=> !busy_ff && started_ff && amp_ff)
        else $error("busy not cleared at start-up completion");
    a_invalid_on_fault: assert property (
        (ce_i && done_pulse && ch_invalid && !diag_go) |=> (code_w[1] == CODE_INVALID))
        else $error("fault did not force invalid code");
    a_code_stable: assert property (
        (ce_i && !done_pulse && !diag_go) |=> $stable(code_w[2]))
        else $error("load code changed outside completion");
    a_short_clear_read: assert property (
        (ce_i && read_clear_ff) |=> (shorts_w[0] == $past({short_load_i[0], short_supply_i[0],
                                                         short_ground_i[0]})))
        else $error("short flags not cleared by full read");
    a_offset_set_read: assert property (
        (ce_i && read_clear_ff) |=> (offset_w == 4'hf))
        else $error("offset latches not set by read");
    a_ac_reset_enable: assert property (
        (ce_i && ac_rise) |=> (ac_w == 4'h0))
        else $error("AC flags not reset on enable");
    a_ac_gated: assert property (
        (ce_i && !ac_active && !ac_rise) |=> $stable(ac_w))
        else $error("AC flag changed while detection inactive");
    a_ac_readback: assert property (
        (ce_i && rd && (wb_adr_i == ADDR_CH0) && ctrl_ff[B_RDSEL]) |=> (wb_dat_o[4] == $past(ac_w[0])))
        else $error("AC flag not shown in readback");
    a_por_cleared: assert property (
        (ce_i && start_rise) |=> !por_ff ##0 diag_release_o)
        else $error("start write did not clear reset flag");
endmodule : amp_load_diagnostics
`default_nettype wire

// >>> sim/load_model.sv
// Far-side model: amplifier ramp and speaker loads
`timescale 1ns/1ps
`default_nettype none
module load_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Control
    input wire logic amp_start_i,
    input wire logic ac_detect_i,
    // Status
    output logic midtap_reached_o,
    output logic shutdown_done_o,
    output logic [3:0] peak_cross_o
);
    logic [3:0] ramp_ff;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ramp_ff <= 4'h0;
            peak_cross_o <= 4'h0;
        end else begin
            ramp_ff <= amp_start_i ? ramp_ff + 4'(ramp_ff != 4'hF) : 4'h0;
            // Sine drive gives a crossing every other cycle; channel 3 has no tweeter
            peak_cross_o <= ac_detect_i ? {1'b0, {3{~peak_cross_o[0]}}} : 4'h0;
        end
    end
    assign midtap_reached_o = ramp_ff == 4'hF;
    assign shutdown_done_o = ~amp_start_i & (ramp_ff == 4'h0);
endmodule : load_model
`default_nettype wire

// >>> sim/tb_amp_load_diagnostics.sv
// Self-checking bench for the load diagnostics block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin mismatches++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module tb_amp_load_diagnostics
    import amp_diag_pkg::*;
;
    logic clk_i = 0, rst_i = 1, ce = 1, cyc = 0, stb = 0, we = 0, dip = 0;
    logic [7:0] adr = 0, dc = 0;
    logic [31:0] wdat = 0, rdat, exp_v, q[$];
    logic [3:0] ov = 0, sg = 0, sl = 0, ss = 0, win = 0, pk;
    logic [5:0] ex[4];
    logic ack, gen, raise, start, acd, hic, rel, mid, sdn;
    int mismatches = 0, n_checks = 0, cyc_n = 0;
    initial forever #4 clk_i = ~clk_i;
    amp_load_diagnostics #(.OFFSET_STEP_CYC(8), .MEAS_CYC(8)) i_amp_load_diagnostics (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .dc_code_i(dc), .over_3v5_i(ov), .supply_dip_i(dip),
        .supply_fault_i(1'b0), .short_load_i(sl), .short_supply_i(ss),
        .short_ground_i(sg), .in_window_i(win), .peak_cross_i(pk),
        .midtap_reached_i(mid), .shutdown_done_i(sdn), .offset_gen_o(gen),
        .offset_raise_o(raise), .amp_start_o(start), .ac_detect_o(acd),
        .ac_high_current_o(hic), .diag_release_o(rel));
    load_model i_load_model (.clk_i(clk_i), .rst_i(rst_i), .amp_start_i(start),
        .ac_detect_i(acd), .midtap_reached_o(mid), .shutdown_done_o(sdn), .peak_cross_o(pk));
    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : stop_test
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d;
        do @(posedge clk_i); while (ack !== 1'b1);
        cyc <= 0; stb <= 0;
        @(posedge clk_i);
    endtask : wb
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        q.push_back(e);
        wb(1'b0, a, 32'h0000_0000);
    endtask : rd
    task automatic diag_wait;
        int n;
        n = 0;
        repeat (3) @(posedge clk_i);
        while (gen === 1'b1 && n < 500) begin @(posedge clk_i); n++; end
        // A diagnostic that never ends counts as a mismatch
        if (n >= 500) mismatches++;
        repeat (2) @(posedge clk_i);
    endtask : diag_wait
    // Full ordered read; afterwards shorts clear and offset latches arm
    task automatic full_rd;
        for (int k = 0; k < 4; k++) rd(ADDR_CH0 + 8'(4 * k), 32'(ex[k]));
        rd(ADDR_STATUS, 32'h0000_0004);
        for (int k = 0; k < 4; k++) ex[k] = {ex[k][5:4], 4'h4};
    endtask : full_rd
    always @(posedge clk_i) begin
        cyc_n++;
        if (cyc_n == 20000) begin
            mismatches++;
            stop_test();
        end else if (ack === 1'b1 && we === 1'b0) begin
            // Pop once: the macro repeats its arguments
            exp_v = q.pop_front();
            `CHK(rdat, exp_v)
        end
    end
    initial begin
        void'($urandom(99));
        dc <= 8'($urandom);
        repeat (2) @(posedge clk_i);
        rst_i <= 0;
        rd(ADDR_STATUS, 32'h0000_0004);
        rd(ADDR_CH0, 32'h0000_0030);
        rd(8'hFC, 32'h0000_0000);
        wb(1'b1, ADDR_CTRL, 32'h0000_0002);
        `CHK({gen, raise}, 2'b10)
        rd(ADDR_STATUS, 32'h0000_0005);
        rd(8'h10, 32'h0000_0030);
        repeat (5) @(posedge clk_i);
        `CHK(raise, 1'b1)
        diag_wait();
        `CHK(raise, 1'b0)
        for (int k = 0; k < 4; k++) ex[k] = {dc[2 * k +: 2], 4'h0};
        rd(ADDR_STATUS, 32'h0000_0004);
        full_rd();
        rd(8'h0C, 32'(ex[1]));
        win <= 4'h1;
        @(posedge clk_i);
        win <= 4'h0;
        ex[0][2] = 1'b0;
        rd(ADDR_CH0, 32'(ex[0]));
        {sl, ss, sg} <= {4'h2, 4'h4, 4'h4};
        @(posedge clk_i);
        {sl, ss, sg} <= 12'h000;
        ex[1][3] = 1'b1;
        ex[2][1:0] = 2'b11;
        rd(8'h10, 32'(ex[2]));
        full_rd();
        rd(8'h10, 32'(ex[2]));
        wb(1'b1, ADDR_CTRL, 32'h0000_0012);
        rd(ADDR_CH3, 32'h0000_0004);
        wb(1'b1, ADDR_CTRL, 32'h0000_0002);
        rd(ADDR_CH3, 32'(ex[3]));
        // Abort by overvoltage, then supply dip (runs to the end, code invalid); toggle restarts each time
        for (int c = 0; c < 2; c++) begin
            {dip, ov} <= (c == 0) ? 5'h02 : 5'h10;
            wb(1'b1, ADDR_CTRL, 32'h0000_0000);
            wb(1'b1, ADDR_CTRL, 32'h0000_0002);
            diag_wait();
            rd(8'h0C, 32'h0000_0034);
        end
        {dip, ov} <= 5'h00;
        wb(1'b1, ADDR_CTRL, 32'h0000_0003);
        diag_wait();
        repeat (30) @(posedge clk_i);
        rd(ADDR_STATUS, 32'h0000_000A);
        rd(ADDR_CH0, 32'({dc[1:0], 4'h4}));
        `CHK({start, rel}, 2'b11)
        wb(1'b1, ADDR_CTRL, 32'h0000_001F);
        repeat (30) @(posedge clk_i);
        `CHK(acd, 1'b1)
        rd(ADDR_CH0, 32'h0000_0014);
        rd(ADDR_CH3, 32'h0000_0004);
        `CHK(hic, 1'b1)
        // Best efficiency on: enable edge clears flags, nothing counts
        wb(1'b1, ADDR_CTRL, 32'h0000_0021);
        wb(1'b1, ADDR_CTRL, 32'h0000_0037);
        repeat (30) @(posedge clk_i);
        `CHK(acd, 1'b0)
        `CHK(hic, 1'b0)
        rd(ADDR_CH0, 32'h0000_0004);
        // Controller repeat order: stop amplifier, wait for shutdown, restart
        wb(1'b1, ADDR_CTRL, 32'h0000_0000);
        repeat (4) @(posedge clk_i);
        rd(ADDR_STATUS, 32'h0000_0000);
        wb(1'b1, ADDR_CTRL, 32'h0000_0002);
        rd(ADDR_STATUS, 32'h0000_0001);
        // Enable low must freeze the running diagnostic
        ce <= 1'b0;
        repeat (30) @(posedge clk_i);
        ce <= 1'b1;
        rd(ADDR_STATUS, 32'h0000_0001);
        diag_wait();
        rd(ADDR_STATUS, 32'h0000_0000);
        stop_test();
    end
endmodule : tb_amp_load_diagnostics
`default_nettype wire
